// [rtl/stc_pkg.sv]
// Shared constants, types and helpers for the sixteen-bit timer/counter
package stc_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] STC_ADDR_CTRL = 3'h0;    // Timer control
  localparam logic [2:0] STC_ADDR_CNT_LO = 3'h1;  // Low count byte
  localparam logic [2:0] STC_ADDR_CNT_HI = 3'h2;  // High count byte or its buffer
  localparam logic [2:0] STC_ADDR_FLAGS = 3'h3;   // Overflow flag and its enable
  // Reset values
  localparam logic [7:0] STC_CTRL_RESET = 8'h00;
  localparam logic [15:0] STC_CNT_RESET = 16'h0000;
  localparam logic [7:0] STC_BYTE_ZERO = 8'h00;
  localparam logic [15:0] STC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] STC_CNT_ONE = 16'h0001;
  // Flags register field positions
  localparam int STC_FLAG_OVF_BIT = 0;
  localparam int STC_FLAG_IE_BIT = 1;
  // System clock select code for the secondary oscillator
  localparam logic [1:0] STC_SYS_CLK_SEC = 2'h1;
  // Core clock timing: instruction cycle is the core clock divided by four
  localparam int STC_CLK_PERIOD_NS = 50;
  localparam logic [1:0] STC_INSTR_LAST = 2'h3;   // Last phase of the divide-by-four
  localparam logic [1:0] STC_DIV_ONE = 2'h1;
  localparam logic [2:0] STC_PRESC_ONE = 3'h1;
  localparam logic [2:0] STC_PRESC_ZERO = 3'h0;

  // Control register image, bit 7 down to bit 0
  typedef struct packed {
    logic wide_access_mode;        // Bit 7
    logic secondary_clock_active;  // Bit 6, read only
    logic [1:0] input_prescale_sel; // Bits 5:4
    logic low_power_osc_enable;    // Bit 3
    logic ext_sync_bypass;         // Bit 2
    logic clock_source_sel;        // Bit 1
    logic count_enable;            // Bit 0
  } stc_ctrl_s;

  // One register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stc_bus_s;

  // Last prescaler count for each select code
  function automatic logic [2:0] stc_presc_top(input logic [1:0] sel);
    logic [2:0] top;
    case (sel)
      2'h3: top = 3'h7;
      2'h2: top = 3'h3;
      2'h1: top = 3'h1;
      default: top = 3'h0;
    endcase
    return top;
  endfunction
endpackage

// [rtl/stc_timer.sv]
// Sixteen-bit timer/counter with prescaler, buffered access and pin takeover
//
// Summary of operation
// RULE1: Counts only while count enable is set.
// RULE2: Wide mode selects buffered sixteen-bit access.
// RULE3: Status bit shows core clocked from oscillator.
// RULE4: Prescale codes divide input by 1,2,4,8.
// RULE5: Oscillator enable bit turns oscillator on/off.
// RULE6: External input synchronised unless bypass set.
// RULE7: Internal source counts once per instruction cycle.
// RULE8: External source counts on rising input edges.
// RULE9: Enabled timer forces pins input, reads zero.
// RULE10: Low byte read captures high byte.
// RULE11: High writes buffered, low write transfers both.
// RULE12: Wide mode reaches high byte only via buffer.
// RULE13: Low write clears prescaler; high write does not.
// RULE14: Oscillator keeps running in power-managed modes.
// RULE15: Software waits oscillator start-up before use.
// RULE16: Control visible only when alternate select clear.
// RULE17: Secondary clock code clocks core from oscillator.
// RULE18: Rollover to zero sets the overflow flag.
// RULE19: Compare trigger clears counter; writes win.
// RULE20: Trigger clear never sets the overflow flag.
// RULE21: Stopped timer holds; register access still works.
// RULE22: Control register resets to all zero.
`timescale 1ns/1ps
module stc_timer
  import stc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire stc_bus_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_alt_reg_sel,
  input wire logic [1:0] i_sys_clk_sel,
  input wire logic i_lp_osc_clk,
  input wire logic i_osc_in_pin,
  input wire logic i_osc_out_pin,
  input wire logic [1:0] i_port_out,
  input wire logic [1:0] i_port_dir_in,
  input wire logic i_cmp_reset,
  output logic o_osc_enable,
  output logic o_sys_clk_from_osc,
  output logic [1:0] o_pin_out,
  output logic [1:0] o_pin_oe,
  output logic [1:0] o_port_read,
  output logic o_overflow_irq
);

  // Stored control fields; the status bit is stored on writes but never read back
  stc_ctrl_s ctrl;
  stc_ctrl_s ctrl_view;        // Control as software reads it
  logic [15:0] cnt;            // Live counter
  logic [15:0] next_cnt;
  logic [7:0] hi_buf;          // High byte buffer for wide access
  logic ovf_flag;              // Sticky overflow flag
  logic ovf_ie;                // Overflow interrupt enable
  logic [1:0] div_cnt;         // Instruction-cycle divider
  logic [2:0] presc_cnt;       // Prescaler count
  logic [2:0] presc_top;       // Prescaler last count
  logic sync_s1;               // Synchroniser first stage
  logic sync_s2;               // Synchroniser second stage
  logic sync_s3;               // Delayed copy for edge detect
  logic raw_q;                 // Previous raw level for bypass edges

  // Decoded accesses
  wire ctrl_sel = (i_bus.addr == STC_ADDR_CTRL) && !i_alt_reg_sel; // RULE16
  wire wr_ctrl = i_bus.wr && ctrl_sel;
  wire wr_lo = i_bus.wr && (i_bus.addr == STC_ADDR_CNT_LO);
  wire wr_hi = i_bus.wr && (i_bus.addr == STC_ADDR_CNT_HI);
  wire wr_flags = i_bus.wr && (i_bus.addr == STC_ADDR_FLAGS);
  wire rd_lo = i_bus.rd && (i_bus.addr == STC_ADDR_CNT_LO);
  wire wide = ctrl.wide_access_mode;
  // Any write that changes the live counter this cycle
  wire cnt_wr = wr_lo || (wr_hi && !wide);

  // Status and oscillator control
  wire sec_run = (i_sys_clk_sel == STC_SYS_CLK_SEC); // RULE3 RULE17
  assign o_sys_clk_from_osc = sec_run; // RULE17
  // The enable is not gated by any power mode, so the crystal keeps running
  assign o_osc_enable = ctrl.low_power_osc_enable; // RULE5 RULE14

  // Counting source selection
  wire ext_level = ctrl.low_power_osc_enable ? i_lp_osc_clk : i_osc_out_pin; // RULE8
  wire inst_tick = (div_cnt == STC_INSTR_LAST); // RULE7
  wire edge_sync = sync_s2 && !sync_s3;
  wire edge_raw = ext_level && !raw_q;
  // Bypass saves two cycles of latency but trusts the input to be clean
  wire ext_tick = ctrl.ext_sync_bypass ? edge_raw : edge_sync; // RULE6
  wire src_tick = ctrl.clock_source_sel ? ext_tick : inst_tick; // RULE7 RULE8
  assign presc_top = stc_presc_top(ctrl.input_prescale_sel);
  wire presc_tick = src_tick && (presc_cnt == presc_top); // RULE4
  wire cnt_inc = ctrl.count_enable && presc_tick; // RULE1
  wire ovf_evt = cnt_inc && !cnt_wr && !i_cmp_reset && (cnt == STC_CNT_MAX); // RULE18 RULE20
  wire clr_ovf = wr_flags && i_bus.wdata[STC_FLAG_OVF_BIT];

  // Read view of control with the live status bit
  always_comb
  begin
    ctrl_view = ctrl;
    ctrl_view.secondary_clock_active = sec_run; // RULE3
  end

  // Read mux; the high address shows the buffer in wide mode
  wire [7:0] hi_view = wide ? hi_buf : cnt[15:8]; // RULE12
  wire [7:0] flags_view = {6'h00, ovf_ie, ovf_flag};
  wire [7:0] rd_mux =
    ctrl_sel ? ctrl_view :
    (i_bus.addr == STC_ADDR_CNT_LO) ? cnt[7:0] :
    (i_bus.addr == STC_ADDR_CNT_HI) ? hi_view :
    (i_bus.addr == STC_ADDR_FLAGS) ? flags_view : STC_BYTE_ZERO;

  // Next counter value: a write beats the trigger, which beats counting
  always_comb
  begin
    next_cnt = cnt;
    if (wr_lo)
    begin
      // Wide mode moves the buffer into the high byte at the same time
      next_cnt = wide ? {hi_buf, i_bus.wdata} : {cnt[15:8], i_bus.wdata}; // RULE2 RULE11
    end
    else if (wr_hi && !wide)
    begin
      next_cnt = {i_bus.wdata, cnt[7:0]}; // RULE2
    end
    else if (i_cmp_reset)
    begin
      next_cnt = STC_CNT_RESET; // RULE19
    end
    else if (cnt_inc)
    begin
      next_cnt = cnt + STC_CNT_ONE; // RULE18
    end
  end

  // Control register; everything clears at reset
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      ctrl <= stc_ctrl_s'(STC_CTRL_RESET); // RULE22
    else if (wr_ctrl)
      ctrl <= stc_ctrl_s'(i_bus.wdata);
  end

  // Counter; holds whenever nothing above changes it
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      cnt <= STC_CNT_RESET;
    else
      cnt <= next_cnt; // RULE21
  end

  // High byte buffer: in wide mode only, written by high byte writes and loaded by low byte reads
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      hi_buf <= STC_BYTE_ZERO;
    else if (wr_hi && wide)
      hi_buf <= i_bus.wdata; // RULE11
    else if (rd_lo && wide)
      hi_buf <= cnt[15:8]; // RULE10
  end

  // Sticky overflow flag: a new overflow wins over a clear
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ovf_flag <= 1'b0;
      ovf_ie <= 1'b0;
    end
    else
    begin
      if (ovf_evt)
        ovf_flag <= 1'b1; // RULE18
      else if (clr_ovf)
        ovf_flag <= 1'b0;
      if (wr_flags)
        ovf_ie <= i_bus.wdata[STC_FLAG_IE_BIT];
    end
  end

  // Interrupt request only when enabled
  assign o_overflow_irq = ovf_flag && ovf_ie; // RULE18

  // Instruction-cycle divider runs freely off the core clock
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      div_cnt <= 2'h0;
    else
      div_cnt <= div_cnt + STC_DIV_ONE; // RULE7
  end

  // Prescaler; only a low byte write clears it
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      presc_cnt <= STC_PRESC_ZERO;
    else if (wr_lo)
      presc_cnt <= STC_PRESC_ZERO; // RULE13
    else if (src_tick && ctrl.count_enable)
      presc_cnt <= presc_tick ? STC_PRESC_ZERO : presc_cnt + STC_PRESC_ONE; // RULE4
  end

  // Edge detection of the external source, synchronised or raw
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_s3 <= 1'b0;
      raw_q <= 1'b0;
    end
    else
    begin
      sync_s1 <= ext_level; // RULE6
      sync_s2 <= sync_s1;
      sync_s3 <= sync_s2;
      raw_q <= ext_level;
    end
  end

  // Registered read data and pin takeover
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= STC_BYTE_ZERO;
      o_pin_out <= 2'h0;
      o_pin_oe <= 2'h0;
      o_port_read <= 2'h0;
    end
    else
    begin
      o_rdata <= i_bus.rd ? rd_mux : STC_BYTE_ZERO;
      o_pin_out <= i_port_out;
      // Enabled timer owns both pins, so the direction bits are ignored
      o_pin_oe <= ctrl.count_enable ? 2'h0 : ~i_port_dir_in; // RULE9
      o_port_read <= ctrl.count_enable ? 2'h0 : {i_osc_in_pin, i_osc_out_pin}; // RULE9
    end
  end

  // Assertion helper: source ticks seen since the last count, kept across stops
  logic [3:0] tick_gap;
  logic gap_valid;            // Low once the prescale code changed in mid-count
  wire stc_ctrl_s wdata_ctrl = stc_ctrl_s'(i_bus.wdata); // Write data as control fields
  wire [3:0] gap_expect = (4'h1 << ctrl.input_prescale_sel) - 4'h1; // Ticks before a count
  wire code_change = wr_ctrl && (wdata_ctrl.input_prescale_sel != ctrl.input_prescale_sel);

  // Tracks the prescaler independently; a code change with a partial count
  // leaves the ratio undefined until the next low byte write
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_gap <= 4'h0;
      gap_valid <= 1'b1;
    end
    else
    begin
      if (wr_lo || cnt_inc)
        tick_gap <= 4'h0;
      else if (src_tick && ctrl.count_enable)
        tick_gap <= tick_gap + 4'h1;
      if (wr_lo)
        gap_valid <= 1'b1;
      else if (code_change && ((tick_gap != 4'h0) || (src_tick && ctrl.count_enable)))
        gap_valid <= 1'b0;
    end
  end

  // Checks next to the logic they guard
  sequence s_inst_gap;
    !inst_tick [*3] ##1 inst_tick;
  endsequence

  sequence s_wide_low_write;
    wr_lo && wide;
  endsequence

  chk_stop_holds: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE1
    !ctrl.count_enable && !i_bus.wr && !i_cmp_reset |=> $stable(cnt))
    else $error("counter moved while stopped");

  chk_instr_rate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE7
    inst_tick |=> s_inst_gap)
    else $error("instruction tick not every four clocks");

  chk_presc_ratio: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE4
    cnt_inc && gap_valid |-> (tick_gap == gap_expect))
    else $error("count without full prescale");

  chk_low_read_copy: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE10
    rd_lo && wide && !wr_hi |=> hi_buf == $past(cnt[15:8]))
    else $error("buffer missed high byte on low read");

  chk_wide_write: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE11
    s_wide_low_write |=> cnt == {$past(hi_buf), $past(i_bus.wdata)})
    else $error("wide write did not load both bytes");

  chk_hi_buffer_read: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE12
    i_bus.rd && wide && (i_bus.addr == STC_ADDR_CNT_HI) |=> o_rdata == $past(hi_buf))
    else $error("wide high read bypassed buffer");

  chk_presc_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE13
    wr_lo |=> presc_cnt == STC_PRESC_ZERO)
    else $error("low write left prescaler count");

  chk_rollover: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE18
    cnt_inc && !cnt_wr && !i_cmp_reset && cnt == STC_CNT_MAX |=> cnt == STC_CNT_RESET && ovf_flag)
    else $error("rollover did not set flag");

  chk_trig_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE19
    i_cmp_reset && !cnt_wr |=> cnt == STC_CNT_RESET)
    else $error("trigger did not clear counter");

  chk_trig_noflag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE20
    i_cmp_reset && !ovf_flag |=> !ovf_flag)
    else $error("trigger set overflow flag");

  chk_pin_takeover: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE9
    ctrl.count_enable |=> o_pin_oe == 2'h0 && o_port_read == 2'h0)
    else $error("pins not released while enabled");

  chk_ctrl_hidden: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE16
    i_bus.wr && i_alt_reg_sel && i_bus.addr == STC_ADDR_CTRL |=> $stable(ctrl))
    else $error("control written while overlaid");

  chk_status_bit: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE3
    i_bus.rd && ctrl_sel |=> o_rdata[6] == ($past(i_sys_clk_sel) == STC_SYS_CLK_SEC))
    else $error("status bit does not follow clock select");

  chk_osc_enable: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE5
    wr_ctrl |=> o_osc_enable == $past(wdata_ctrl.low_power_osc_enable))
    else $error("oscillator enable does not follow control");

  chk_hi_keeps_presc: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE13
    wr_hi && !(src_tick && ctrl.count_enable) |=> $stable(presc_cnt))
    else $error("high write disturbed prescaler");

  chk_flag_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE18
    ovf_evt |=> ovf_flag)
    else $error("overflow event lost");

  chk_narrow_hi_read: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE2
    i_bus.rd && !wide && (i_bus.addr == STC_ADDR_CNT_HI) |=> o_rdata == $past(cnt[15:8]))
    else $error("byte mode high read not live");

  chk_count_step: assert property (@(posedge i_ref_clk) disable iff (i_rst) // RULE1
    cnt_inc && !cnt_wr && !i_cmp_reset && (cnt != STC_CNT_MAX) |=> cnt == $past(cnt) + STC_CNT_ONE)
    else $error("enabled count did not step by one");

endmodule

// [tb/stc_osc_model.sv]
// Behavioural low-power crystal oscillator standing beside the timer
`timescale 1ns/1ps
module stc_osc_model
(
  input wire logic i_ref_clk,
  input wire logic i_enable,
  output logic o_clk
);
  // Output rests low while no burst is running, so no stray edge is counted
  initial o_clk = 1'b0;

  // A burst of rising edges; a switched-off oscillator gives a flat line
  // It ignores the system clock mode, as the crystal keeps running in every one
  task automatic burst(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge i_ref_clk);
      o_clk <= i_enable;
      repeat (half) @(posedge i_ref_clk);
      o_clk <= 1'b0;
    end
  endtask
endmodule

// [tb/stc_timer_tb_top.sv]
// Self-checking testbench for the sixteen-bit timer/counter
`timescale 1ns/1ps
module stc_timer_tb_top;
  import stc_pkg::*;
  logic i_ref_clk;
  logic i_rst;
  stc_bus_s i_bus;
  logic [7:0] o_rdata;
  logic i_alt_reg_sel;
  logic [1:0] i_sys_clk_sel;
  logic lp_clk;
  logic i_osc_in_pin;
  logic i_osc_out_pin;
  logic [1:0] i_port_out;
  logic [1:0] i_port_dir_in;
  logic i_cmp_reset;
  logic o_osc_enable;
  logic o_sys_clk_from_osc;
  logic [1:0] o_pin_out;
  logic [1:0] o_pin_oe;
  logic [1:0] o_port_read;
  logic o_overflow_irq;
  int error_cnt;
  int n_checks;
  int seed;
  logic [7:0] rv;
  logic [7:0] rh;

  stc_timer i_stc_timer (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_alt_reg_sel(i_alt_reg_sel), .i_sys_clk_sel(i_sys_clk_sel),
    .i_lp_osc_clk(lp_clk), .i_osc_in_pin(i_osc_in_pin), .i_osc_out_pin(i_osc_out_pin),
    .i_port_out(i_port_out), .i_port_dir_in(i_port_dir_in), .i_cmp_reset(i_cmp_reset),
    .o_osc_enable(o_osc_enable), .o_sys_clk_from_osc(o_sys_clk_from_osc),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_port_read(o_port_read),
    .o_overflow_irq(o_overflow_irq));

  stc_osc_model i_stc_osc_model (.i_ref_clk(i_ref_clk), .i_enable(o_osc_enable),
    .o_clk(lp_clk));

  // Core clock, 50 ns period
  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // Exact value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Count compare with one tick of slack, since the divider phase is free-running
  task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
    n_checks++;
    if ((got < lo) !== 1'b0 || (got > hi) !== 1'b0)
    begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h..%0h", $time, got, lo, hi);
    end
  endtask

  // Expected ticks: instruction cycle is four core clocks, then the prescaler
  function automatic int ticks(input int cyc, input int code);
    return cyc / (4 << code);
  endfunction

  // One-cycle write strobe; the trailing step lets that edge's updates land
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_bus <= {a, d, 2'b10};
    @(posedge i_ref_clk);
    i_bus <= '0;
    #1;
  endtask

  // One-cycle read strobe; data is taken in the single cycle where it stands
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_bus <= {a, 8'h00, 2'b01};
    @(posedge i_ref_clk);
    i_bus <= '0;
    #1;
    d = o_rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(d, exp);
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard: a run that never finishes counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    error_cnt++;
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    seed = 30281;
    error_cnt = 0;
    n_checks = 0;
    i_rst = 1'b1;
    i_bus = '0;
    i_alt_reg_sel = 1'b0;
    i_sys_clk_sel = 2'h0;
    i_osc_in_pin = 1'b0;
    i_osc_out_pin = 1'b0;
    i_port_out = 2'h0;
    i_port_dir_in = 2'h0;
    i_cmp_reset = 1'b0;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd_chk(STC_ADDR_CTRL, STC_CTRL_RESET);
    rd_chk(STC_ADDR_CNT_LO, STC_BYTE_ZERO);
    rd_chk(3'h5, 8'h00);
    // Every prescale code on the internal source, with random pin levels
    for (int c = 0; c < 4; c++)
    begin
      rv = 8'($random(seed));
      {i_osc_in_pin, i_osc_out_pin, i_port_dir_in, i_port_out} <= rv[5:0];
      bus_wr(STC_ADDR_CNT_LO, 8'h00);
      bus_wr(STC_ADDR_CTRL, {2'b00, c[1:0], 4'h1});
      repeat (126) @(posedge i_ref_clk);
      chk({o_pin_oe, o_port_read}, 16'h0000);
      bus_wr(STC_ADDR_CTRL, 8'h00);
      bus_rd(STC_ADDR_CNT_LO, rh);
      chk_rng(rh, ticks(128, c) - 1, ticks(128, c) + 1);
      repeat (30) @(posedge i_ref_clk);
      rd_chk(STC_ADDR_CNT_LO, rh);
      chk({o_pin_oe, o_port_read}, {~rv[3:2], rv[5:4]});
      chk(o_pin_out, rv[1:0]);
    end
    // Wide mode: buffered high byte, loaded on low write, captured on low read
    rv = 8'($random(seed));
    rh = 8'($random(seed));
    bus_wr(STC_ADDR_CTRL, 8'h80);
    bus_wr(STC_ADDR_CNT_HI, rh);
    bus_wr(STC_ADDR_CNT_LO, rv);
    bus_wr(STC_ADDR_CNT_HI, ~rh);
    rd_chk(STC_ADDR_CNT_LO, rv);
    rd_chk(STC_ADDR_CNT_HI, rh);
    bus_wr(STC_ADDR_CTRL, 8'h00);
    rd_chk(STC_ADDR_CNT_HI, rh);
    // Rollover near the top sets the sticky flag
    bus_wr(STC_ADDR_CNT_HI, 8'hFF);
    bus_wr(STC_ADDR_CNT_LO, 8'hFE);
    bus_wr(STC_ADDR_CTRL, 8'h01);
    repeat (20) @(posedge i_ref_clk);
    bus_wr(STC_ADDR_CTRL, 8'h00);
    rd_chk(STC_ADDR_CNT_HI, 8'h00);
    rd_chk(STC_ADDR_FLAGS, 8'h01);
    bus_wr(STC_ADDR_FLAGS, 8'h02);
    chk(o_overflow_irq, 1'b1);
    bus_wr(STC_ADDR_FLAGS, 8'h03);
    chk(o_overflow_irq, 1'b0);
    // Compare trigger clears without a flag; a coinciding write wins
    @(posedge i_ref_clk);
    i_cmp_reset <= 1'b1;
    @(posedge i_ref_clk);
    i_cmp_reset <= 1'b0;
    rd_chk(STC_ADDR_CNT_LO, 8'h00);
    rd_chk(STC_ADDR_FLAGS, 8'h02);
    @(posedge i_ref_clk);
    i_cmp_reset <= 1'b1;
    i_bus <= {STC_ADDR_CNT_LO, 8'h55, 2'b10};
    @(posedge i_ref_clk);
    i_cmp_reset <= 1'b0;
    i_bus <= '0;
    rd_chk(STC_ADDR_CNT_LO, 8'h55);
    // Every system clock select code against the status bit
    for (int s = 0; s < 4; s++)
    begin
      @(posedge i_ref_clk);
      i_sys_clk_sel <= s[1:0];
      rd_chk(STC_ADDR_CTRL, {1'b0, s == 1, 6'h00});
      chk(o_sys_clk_from_osc, s == 1);
    end
    // Alternate select hides the control register
    @(posedge i_ref_clk);
    i_alt_reg_sel <= 1'b1;
    bus_wr(STC_ADDR_CTRL, 8'h01);
    rd_chk(STC_ADDR_CTRL, 8'h00);
    @(posedge i_ref_clk);
    i_alt_reg_sel <= 1'b0;
    rd_chk(STC_ADDR_CTRL, {1'b0, i_sys_clk_sel == 2'h1, 6'h00});
    // Oscillator as count source, synchronised then bypassed
    for (int b = 0; b < 2; b++)
    begin
      bus_wr(STC_ADDR_CNT_LO, 8'h00);
      bus_wr(STC_ADDR_CTRL, {5'b00001, b[0], 2'b11});
      chk(o_osc_enable, 1'b1);
      repeat (40) @(posedge i_ref_clk);
      i_stc_osc_model.burst(5 + b, 4);
      repeat (10) @(posedge i_ref_clk);
      bus_wr(STC_ADDR_CTRL, 8'h00);
      chk(o_osc_enable, 1'b0);
      rd_chk(STC_ADDR_CNT_LO, 8'(5 + b));
    end
    // External pin as count source with the oscillator off
    i_osc_out_pin <= 1'b0;
    bus_wr(STC_ADDR_CNT_LO, 8'h00);
    bus_wr(STC_ADDR_CTRL, 8'h03);
    repeat (3)
    begin
      repeat (4) @(posedge i_ref_clk);
      i_osc_out_pin <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      i_osc_out_pin <= 1'b0;
    end
    repeat (6) @(posedge i_ref_clk);
    bus_wr(STC_ADDR_CTRL, 8'h00);
    rd_chk(STC_ADDR_CNT_LO, 8'h03);
    report_and_stop;
  end
endmodule
